// [sim/pmc_power_mode_controller_checker.sv]
// Purpose: Port-level checks of the power mode controller
// Assumes: Single clock domain, async active-low reset
// Notes: Attached by bind to every controller instance
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.vh"
module pmc_power_mode_controller_checker
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic instr_done_in,
    input wire logic irq_pending_in,
    input wire logic [`PMC_ANA_W-1:0] ana_disable_in,
    input wire logic [2:0] mode_out,
    input wire logic idle_select_bit_out,
    input wire logic stop_select_bit_out,
    input wire logic cpu_halt_out,
    input wire logic sysclk_gate_out,
    input wire logic prec_osc_en_out,
    input wire logic lp_osc_en_out,
    input wire logic core_supply_en_out,
    input wire logic dig_periph_pwr_out,
    input wire logic periph_clk_en_out,
    input wire logic [`PMC_ANA_W-1:0] ana_en_out,
    input wire logic [`PMC_WAKE_W-1:0] wake_flags_out
);
default clocking cb @(posedge clk_in); endclocking
default disable iff (!arst_n_in);
sequence s_idle_wake;
    mode_out == `PMC_MODE_IDLE ##1 mode_out == `PMC_MODE_NORMAL;
endsequence
sequence s_susp_wake;
    mode_out == `PMC_MODE_SUSPEND ##1 mode_out == `PMC_MODE_NORMAL;
endsequence
AST_HALT: assert property (
    cpu_halt_out == (mode_out != `PMC_MODE_NORMAL)) else $error("halt bad");
AST_IDLE: assert property (mode_out == `PMC_MODE_IDLE |->
    periph_clk_en_out && prec_osc_en_out) else $error("idle clocks bad");
AST_STOP: assert property (mode_out == `PMC_MODE_STOP |->
    !prec_osc_en_out && stop_select_bit_out) else $error("stop bad");
AST_STAY: assert property (mode_out == `PMC_MODE_STOP |=>
    mode_out == `PMC_MODE_STOP) else $error("stop left");
AST_SUSP: assert property (mode_out == `PMC_MODE_SUSPEND |->
    sysclk_gate_out && !lp_osc_en_out && !prec_osc_en_out)
    else $error("suspend bad");
AST_SLEEP: assert property (mode_out == `PMC_MODE_SLEEP |->
    !core_supply_en_out && !dig_periph_pwr_out && !lp_osc_en_out)
    else $error("sleep bad");
AST_ENTRY: assert property (mode_out == `PMC_MODE_NORMAL &&
    !instr_done_in |=> mode_out == `PMC_MODE_NORMAL) else $error("entry");
AST_IDLEWAKE: assert property (mode_out == `PMC_MODE_IDLE &&
    irq_pending_in |-> ##[1:2] mode_out == `PMC_MODE_NORMAL)
    else $error("idle wake late");
AST_CLEAR: assert property (s_idle_wake |->
    !idle_select_bit_out) else $error("idle bit kept");
AST_FLAGS: assert property (s_susp_wake |->
    (wake_flags_out == 5'h00) [*3]) else $error("flags early");
AST_ANA: assert property (arst_n_in |=>
    ana_en_out == ~$past(ana_disable_in)) else $error("analog enable bad");
endmodule // pmc_power_mode_controller_checker
bind pmc_power_mode_controller pmc_power_mode_controller_checker chk
(
    .clk_in, .arst_n_in, .instr_done_in, .irq_pending_in, .ana_disable_in,
    .mode_out, .idle_select_bit_out, .stop_select_bit_out, .cpu_halt_out,
    .sysclk_gate_out, .prec_osc_en_out, .lp_osc_en_out, .core_supply_en_out,
    .dig_periph_pwr_out, .periph_clk_en_out, .ana_en_out, .wake_flags_out
);
`default_nettype wire

// [sim/testbench.sv]
// Purpose: Self-checking bench of the power mode controller
// Assumes: 10 MHz clock, bench drives all ports
// Notes: Stop scenario runs last as it ends in reset
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.vh"
module testbench;
reg clk_in = 0, arst_n_in = 0, idle_set_in = 0, stop_set_in = 0;
reg suspend_set_in = 0, sleep_set_in = 0, instr_done_in = 0;
reg irq_pending_in = 0, two_cell_in = 1;
reg [`PMC_WAKE_W-1:0] wake_en_in = 5'h1f, src = 5'h00;
reg [`PMC_ANA_W-1:0] ana_disable_in = 4'h0, ana_lowpwr_in = 4'h0;
wire rtc_fail_in = src[0], rtc_alarm_in = src[1], port_match_in = src[2];
wire cmp0_in = src[3], rst_pin_n_in = ~src[4];
wire [2:0] mode_out;
wire idle_select_bit_out, stop_select_bit_out, cpu_halt_out, wake_out;
wire sysclk_gate_out, prec_osc_en_out, lp_osc_en_out, core_supply_en_out;
wire dig_periph_pwr_out, periph_clk_en_out;
wire [`PMC_ANA_W-1:0] ana_en_out, ana_lp_out;
wire [`PMC_WAKE_W-1:0] wake_flags_out;
integer mismatches = 0, comparisons = 0, m, b;
pmc_power_mode_controller dut
(
    .clk_in, .arst_n_in, .idle_set_in, .stop_set_in, .suspend_set_in,
    .sleep_set_in, .instr_done_in, .irq_pending_in, .wake_en_in,
    .rtc_fail_in, .rtc_alarm_in, .port_match_in, .cmp0_in, .rst_pin_n_in,
    .two_cell_in, .ana_disable_in, .ana_lowpwr_in, .mode_out,
    .idle_select_bit_out, .stop_select_bit_out, .cpu_halt_out,
    .sysclk_gate_out, .prec_osc_en_out, .lp_osc_en_out, .core_supply_en_out,
    .dig_periph_pwr_out, .periph_clk_en_out, .ana_en_out, .ana_lp_out,
    .wake_flags_out, .wake_out
);
initial forever #50 clk_in = ~clk_in;
task chk(input [8*6:1] nm, input [7:0] e, input [7:0] g);
begin
    comparisons = comparisons + 1;
    if (g !== e)
    begin
        $display("wrong value %0s expected %h seen %h", nm, e, g);
        mismatches = mismatches + 1;
    end
end
endtask
task tick(input integer n);
    repeat (n) @(posedge clk_in);
endtask
task enter(input [2:0] md);
begin
    @(posedge clk_in);
    idle_set_in <= md == `PMC_MODE_IDLE;
    stop_set_in <= md == `PMC_MODE_STOP;
    suspend_set_in <= md == `PMC_MODE_SUSPEND;
    sleep_set_in <= md == `PMC_MODE_SLEEP;
    @(posedge clk_in);
    {idle_set_in, stop_set_in, suspend_set_in, sleep_set_in} <= 4'h0;
    instr_done_in <= 1;
    @(posedge clk_in);
    instr_done_in <= 0;
    @(negedge clk_in);
    chk("mode", md, mode_out);
end
endtask
task wait_normal;
    integer k;
begin
    k = 0;
    while (mode_out !== `PMC_MODE_NORMAL && k < 12)
    begin
        @(negedge clk_in);
        k = k + 1;
    end
    chk("mode", `PMC_MODE_NORMAL, mode_out);
end
endtask
task t_idle;
begin
    enter(`PMC_MODE_IDLE);
    chk("idlbit", 1, idle_select_bit_out);
    chk("pclk", 1, periph_clk_en_out);
    @(posedge clk_in) irq_pending_in <= 1;
    wait_normal;
    chk("wake", 1, wake_out);
    chk("idlbit", 0, idle_select_bit_out);
    @(posedge clk_in) irq_pending_in <= 0;
end
endtask
task t_wake(input [2:0] md, input integer s);
begin
    enter(md);
    chk("gate", 1, sysclk_gate_out);
    chk("supply", md != `PMC_MODE_SLEEP, core_supply_en_out);
    chk("digpwr", md != `PMC_MODE_SLEEP, dig_periph_pwr_out);
    @(posedge clk_in) src[s] <= 1;
    wait_normal;
    chk("wake", 1, wake_out);
    if (md == `PMC_MODE_SUSPEND) chk("flags", 0, wake_flags_out);
    tick(3);
    @(negedge clk_in) chk("flags", 1 << s, wake_flags_out);
    chk("wake", 0, wake_out);
    @(posedge clk_in) src <= 5'h00;
    tick(6);
end
endtask
task t_refuse;
begin
    two_cell_in <= 0;
    wake_en_in <= 5'h1d;
    enter(`PMC_MODE_SLEEP);
    @(posedge clk_in) src <= 5'h0a;
    tick(12);
    @(negedge clk_in) chk("mode", `PMC_MODE_SLEEP, mode_out);
    @(posedge clk_in) src <= 5'h0b;
    wait_normal;
    @(posedge clk_in) src <= 5'h00;
    two_cell_in <= 1;
    wake_en_in <= 5'h1f;
    tick(6);
end
endtask
task t_ana;
begin
    @(posedge clk_in) ana_disable_in <= 4'h5;
    ana_lowpwr_in <= 4'h3;
    tick(2);
    @(negedge clk_in) chk("anaen", 4'ha, ana_en_out);
    chk("analp", 4'h3, ana_lp_out);
end
endtask
task t_stop;
begin
    enter(`PMC_MODE_STOP);
    chk("posc", 0, prec_osc_en_out);
    @(posedge clk_in) src <= 5'h1f;
    irq_pending_in <= 1;
    tick(12);
    @(negedge clk_in) chk("mode", `PMC_MODE_STOP, mode_out);
    @(posedge clk_in) arst_n_in <= 0;
    tick(2);
    arst_n_in <= 1;
    @(negedge clk_in) chk("mode", `PMC_MODE_NORMAL, mode_out);
end
endtask
task print_verdict;
begin
    if (mismatches == 0 && comparisons > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
end
endtask
initial
begin
    #(100 * 4000);
    mismatches = mismatches + 1;
    print_verdict;
end
initial
begin
    tick(16);
    arst_n_in <= 1;
    @(negedge clk_in) chk("supply", 1, core_supply_en_out);
    t_idle;
    for (m = 3; m < 5; m = m + 1)
        for (b = 0; b < 5; b = b + 1)
            t_wake(m, b);
    t_refuse;
    t_ana;
    t_stop;
    print_verdict;
end
endmodule // testbench
`default_nettype wire

// [src/pmc_consts.vh]
// Purpose: Constants for the power mode controller
// Assumes: 10 MHz system clock
// Notes: Mode codes, wake flag positions, timing counts
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

`define PMC_MODE_NORMAL 3'h0
`define PMC_MODE_IDLE 3'h1
`define PMC_MODE_STOP 3'h2
`define PMC_MODE_SUSPEND 3'h3
`define PMC_MODE_SLEEP 3'h4
`define PMC_MODE_RESET_VAL 3'h0

`define PMC_WAKE_RTC_FAIL 0
`define PMC_WAKE_RTC_ALARM 1
`define PMC_WAKE_PORT_MATCH 2
`define PMC_WAKE_CMP0 3
`define PMC_WAKE_RST_PIN 4
`define PMC_WAKE_W 5
`define PMC_FLAGS_RESET_VAL 5'h00
`define PMC_ANA_W 4
`define PMC_ANA_RESET_VAL 4'h0

`define PMC_FLAG_HOLD_CLKS 2'h2

`endif

// [src/pmc_power_mode_controller.v]
// Purpose: Power management unit moving the core between five power modes
// Assumes: Wake pins asynchronous; cpu strobes synchronous to clk_in
// Notes: Stop mode is left only by the system reset input
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.vh"

// Summary of operation
// - Five modes exist and this unit controls entry into and exit from each.
// - Idle halts the cpu, keeps peripherals running, wakes on an interrupt.
// - Stop halts the cpu and precision oscillator; only a reset ends it.
// - Suspend gates the system clock and stops all internal oscillators.
// - Suspend ends on rtc, port match, comparator 0 or reset pin, no reset.
// - Sleep gates core supply, keeps only the rtc oscillator, same wakes.
// - Comparator 0 wakes sleep only in two-cell supply operation.
// - Sleep removes power from all digital peripherals.
// - Each analog peripheral may be disabled or low-power on its own.
// - The idle bit enters idle after its instruction; interrupts clear it.
// - The stop bit enters stop after its instruction; exit is a reset.
// - Wake flags read zero for three clocks after a suspend wake-up.
module pmc_power_mode_controller
(
    input wire clk_in,
    input wire arst_n_in,
    input wire idle_set_in,
    input wire stop_set_in,
    input wire suspend_set_in,
    input wire sleep_set_in,
    input wire instr_done_in,
    input wire irq_pending_in,
    input wire [`PMC_WAKE_W-1:0] wake_en_in,
    input wire rtc_fail_in,
    input wire rtc_alarm_in,
    input wire port_match_in,
    input wire cmp0_in,
    input wire rst_pin_n_in,
    input wire two_cell_in,
    input wire [`PMC_ANA_W-1:0] ana_disable_in,
    input wire [`PMC_ANA_W-1:0] ana_lowpwr_in,
    output reg [2:0] mode_out,
    output reg idle_select_bit_out,
    output reg stop_select_bit_out,
    output reg cpu_halt_out,
    output reg sysclk_gate_out,
    output reg prec_osc_en_out,
    output reg lp_osc_en_out,
    output reg core_supply_en_out,
    output reg dig_periph_pwr_out,
    output reg periph_clk_en_out,
    output reg [`PMC_ANA_W-1:0] ana_en_out,
    output reg [`PMC_ANA_W-1:0] ana_lp_out,
    output reg [`PMC_WAKE_W-1:0] wake_flags_out,
    output reg wake_out
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire [`PMC_WAKE_W-1:0] raw_src;
    wire [`PMC_WAKE_W-1:0] sync_src;
    assign raw_src = {~rst_pin_n_in, cmp0_in, port_match_in,
                      rtc_alarm_in, rtc_fail_in};

    genvar gi;
    generate
        for (gi = 0; gi < `PMC_WAKE_W; gi = gi + 1)
        begin : g_sync
            pmc_sync u_sync
            (
                .clk_in(clk_in),
                .arst_n_in(arst_n_in),
                .d_in(raw_src[gi]),
                .q_out(sync_src[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Wake decode
    reg [`PMC_WAKE_W-1:0] prev_q;
    wire [`PMC_WAKE_W-1:0] rise;
    reg [`PMC_WAKE_W-1:0] src_ok;
    reg [2:0] mode_q;
    reg [2:0] mode_d;

    assign rise = sync_src & ~prev_q;

    always @*
    begin
        src_ok = wake_en_in;
        if (mode_q == `PMC_MODE_SLEEP && !two_cell_in)
            src_ok[`PMC_WAKE_CMP0] = 1'b0;
    end

    wire [`PMC_WAKE_W-1:0] wake_hit;
    wire low_wake;
    assign wake_hit = rise & src_ok;
    assign low_wake = |wake_hit;

    ////////////////////////////////////////////////////////////////////////
    // Mode state machine
    reg pend_idle_q;
    reg pend_stop_q;
    reg pend_susp_q;
    reg pend_sleep_q;
    reg [1:0] hold_q;
    reg [`PMC_WAKE_W-1:0] flags_q;

    always @*
    begin
        mode_d = mode_q;
        case (mode_q)
            `PMC_MODE_NORMAL:
            begin
                if (instr_done_in)
                begin
                    if (pend_stop_q)
                        mode_d = `PMC_MODE_STOP;
                    else if (pend_sleep_q)
                        mode_d = `PMC_MODE_SLEEP;
                    else if (pend_susp_q)
                        mode_d = `PMC_MODE_SUSPEND;
                    else if (pend_idle_q)
                        mode_d = `PMC_MODE_IDLE;
                end
            end
            `PMC_MODE_IDLE:
                if (irq_pending_in)
                    mode_d = `PMC_MODE_NORMAL;
            `PMC_MODE_STOP:
                mode_d = `PMC_MODE_STOP;
            `PMC_MODE_SUSPEND:
                if (low_wake)
                    mode_d = `PMC_MODE_NORMAL;
            `PMC_MODE_SLEEP:
                if (low_wake)
                    mode_d = `PMC_MODE_NORMAL;
            default:
                mode_d = `PMC_MODE_NORMAL;
        endcase
    end

    wire leaving;
    assign leaving = (mode_q != `PMC_MODE_NORMAL) &&
                     (mode_d == `PMC_MODE_NORMAL);

    always @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            mode_q <= `PMC_MODE_RESET_VAL;
            prev_q <= `PMC_FLAGS_RESET_VAL;
            pend_idle_q <= 1'b0;
            pend_stop_q <= 1'b0;
            pend_susp_q <= 1'b0;
            pend_sleep_q <= 1'b0;
            hold_q <= 2'h0;
            flags_q <= `PMC_FLAGS_RESET_VAL;
        end
        else
        begin
            mode_q <= mode_d;
            prev_q <= sync_src;
            // Idle, suspend, sleep requests cleared on wake; a set in the wake cycle is lost
            if (leaving)
            begin
                pend_idle_q <= 1'b0;
                pend_susp_q <= 1'b0;
                pend_sleep_q <= 1'b0;
            end
            else
            begin
                if (idle_set_in)
                    pend_idle_q <= 1'b1;
                if (suspend_set_in)
                    pend_susp_q <= 1'b1;
                if (sleep_set_in)
                    pend_sleep_q <= 1'b1;
            end
            if (stop_set_in)
                pend_stop_q <= 1'b1;
            if (low_wake && mode_q != `PMC_MODE_NORMAL)
                flags_q <= wake_hit;
            else if (mode_d != `PMC_MODE_NORMAL &&
                     mode_q == `PMC_MODE_NORMAL)
                flags_q <= `PMC_FLAGS_RESET_VAL;
            if (leaving && mode_q == `PMC_MODE_SUSPEND)
                hold_q <= `PMC_FLAG_HOLD_CLKS;
            else if (hold_q != 2'h0)
                hold_q <= hold_q - 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered controls
    wire nx_normal;
    wire nx_idle;
    wire nx_stop;
    wire nx_susp;
    wire nx_sleep;
    assign nx_normal = (mode_d == `PMC_MODE_NORMAL);
    assign nx_idle = (mode_d == `PMC_MODE_IDLE);
    assign nx_stop = (mode_d == `PMC_MODE_STOP);
    assign nx_susp = (mode_d == `PMC_MODE_SUSPEND);
    assign nx_sleep = (mode_d == `PMC_MODE_SLEEP);

    always @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            mode_out <= `PMC_MODE_RESET_VAL;
            idle_select_bit_out <= 1'b0;
            stop_select_bit_out <= 1'b0;
            cpu_halt_out <= 1'b0;
            sysclk_gate_out <= 1'b0;
            prec_osc_en_out <= 1'b1;
            lp_osc_en_out <= 1'b1;
            core_supply_en_out <= 1'b1;
            dig_periph_pwr_out <= 1'b1;
            periph_clk_en_out <= 1'b1;
            ana_en_out <= `PMC_ANA_RESET_VAL;
            ana_lp_out <= `PMC_ANA_RESET_VAL;
            wake_flags_out <= `PMC_FLAGS_RESET_VAL;
            wake_out <= 1'b0;
        end
        else
        begin
            mode_out <= mode_d;
            idle_select_bit_out <= (pend_idle_q | idle_set_in) & ~leaving;
            stop_select_bit_out <= pend_stop_q | stop_set_in;
            cpu_halt_out <= ~nx_normal;
            sysclk_gate_out <= nx_susp | nx_sleep;
            prec_osc_en_out <= nx_normal | nx_idle;
            lp_osc_en_out <= ~(nx_susp | nx_sleep);
            core_supply_en_out <= ~nx_sleep;
            dig_periph_pwr_out <= ~nx_sleep;
            periph_clk_en_out <= nx_normal | nx_idle;
            ana_en_out <= ~ana_disable_in;
            ana_lp_out <= ana_lowpwr_in;
            if (hold_q != 2'h0 || (leaving && mode_q == `PMC_MODE_SUSPEND))
                wake_flags_out <= `PMC_FLAGS_RESET_VAL;
            else
                wake_flags_out <= flags_q;
            wake_out <= leaving;
        end
    end
endmodule // pmc_power_mode_controller
`default_nettype wire

// [src/pmc_sync.v]
// Purpose: Three-flop input synchroniser with agreement filter
// Assumes: One clock domain
// Notes: Output changes once the second and third stage agree
`timescale 1ns/1ps
`default_nettype none
module pmc_sync
(
    input wire clk_in,
    input wire arst_n_in,
    input wire d_in,
    output reg q_out
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    always @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            q_out <= 1'b0;
        end
        else
        begin
            s1_q <= d_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                q_out <= s3_q;
        end
    end
endmodule // pmc_sync
`default_nettype wire
